// ==== hdl/pm_timer_pkg.sv ====
package pm_timer_pkg;
   // register byte addresses
   localparam logic [7:0] ctrl_off       = 8'h00;
   localparam logic [7:0] count_off      = 8'h04;
   localparam logic [7:0] period_off     = 8'h08;
   localparam logic [7:0] int_status_off = 8'h0c;
   localparam logic [7:0] int_mask_off   = 8'h10;
   // control field positions
   localparam int presc_lsb  = 0;
   localparam int on_bit     = 2;
   localparam int posts_lsb  = 3;
   localparam int ctrl_width = 7;
   // reset values
   localparam logic [6:0] ctrl_rst   = 7'h00;
   localparam logic [7:0] count_rst  = 8'h00;
   localparam logic [7:0] period_rst = 8'hff;
   // prescale divide counts minus one
   localparam logic [3:0] div4_last  = 4'h3;
   localparam logic [3:0] div16_last = 4'hf;
   // interrupt status bit
   localparam int irq_match_bit = 0;

   typedef struct packed {
      logic [3:0] postscale_select;
      logic       timer_on;
      logic [1:0] prescale_select;
   } timer_control_t;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [7:0]  addr;
      logic [31:0] wdata;
   } reg_access_t;
endpackage

// ==== hdl/prescaler.sv ====
`timescale 1ns/1ps
module prescaler (
   input  wire logic       hclk,
   input  wire logic       hresetn,
   input  wire logic       clear,
   input  wire logic       run,
   input  wire logic [1:0] prescale_select,
   output logic            tick
);
   logic [3:0] cnt_reg;
   logic [3:0] cnt_next;
   logic [3:0] last;

   // 00 -> 1:1, 01 -> 1:4, 1x -> 1:16
   assign last = prescale_select[1] ? pm_timer_pkg::div16_last :
                 (prescale_select[0] ? pm_timer_pkg::div4_last : 4'h0);
   assign tick = run && !clear && (cnt_reg >= last);
   assign cnt_next = (clear || tick) ? 4'h0 :
                     (run ? cnt_reg + 4'h1 : cnt_reg);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_reg <= 4'h0;
      end else begin
         cnt_reg <= cnt_next;
      end
   end

   property p_tick_needs_run;
      @(posedge hclk) disable iff (!hresetn) tick |-> run && !clear;
   endproperty
   a_tick_needs_run: assert property (p_tick_needs_run)
      else $error("prescaler ticked while stopped or cleared");

   property p_div16_spacing;
      @(posedge hclk) disable iff (!hresetn)
         (tick && prescale_select == 2'b10) ##1
         (run && !clear && prescale_select == 2'b10) [*8] |-> !tick;
   endproperty
   a_div16_spacing: assert property (p_div16_spacing)
      else $error("1:16 prescale ticked too early");
endmodule

// ==== hdl/period_match_timer.sv ====
// Decided for this implementation: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
// Overview of operation
// - 8-bit count and period registers, both readable and writable.
// - input clock passes a prescaler of 1:1, 1:4 or 1:16.
// - postscale field bits 6:3 counts matches; value N gives N+1.
// - interrupt raised on count equal period, after the postscaler.
// - match signal offered as gate source to companion timer.
// - match signal offered as shift clock to serial ports.
// - control bit 2 enables timer; cleared stops counting.
// - prescaler and postscaler cleared by count write, control write, reset.
// - control write leaves count register unchanged.
module period_match_timer (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   output logic             irq,
   output logic             gate_match,
   output logic             shift_clock
);
   // ----------------------------------------------------------------
   // bus slave
   // ----------------------------------------------------------------
   pm_timer_pkg::reg_access_t  acc_reg;
   pm_timer_pkg::reg_access_t  acc_next;
   pm_timer_pkg::timer_control_t ctrl_reg;
   logic [7:0]  count_value_reg;
   logic [7:0]  count_value_next;
   logic [7:0]  period_value_reg;
   logic [3:0]  post_cnt_reg;
   logic [3:0]  post_cnt_next;
   logic        status_reg;
   logic        status_next;
   logic        mask_reg;
   logic        match_pulse_reg;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic        take;
   logic        wr_ctrl;
   logic        wr_count;
   logic        wr_period;
   logic        wr_status;
   logic        wr_mask;
   logic        presc_clear;
   logic        tick;
   logic        match;
   logic        match_tick;
   logic        post_done;
   logic        rd_take;
   logic [31:0] rd_ctrl;
   logic [31:0] rd_count;
   logic [31:0] rd_period;
   logic [31:0] rd_status;
   logic [31:0] rd_mask;

   assign take = hsel && hready && htrans[1];
   assign acc_next.wr    = take && hwrite;
   assign acc_next.rd    = take && !hwrite;
   assign acc_next.addr  = haddr[7:0];
   assign acc_next.wdata = 32'h0;

   assign wr_ctrl   = acc_reg.wr && acc_reg.addr == pm_timer_pkg::ctrl_off;
   assign wr_count  = acc_reg.wr && acc_reg.addr == pm_timer_pkg::count_off;
   assign wr_period = acc_reg.wr && acc_reg.addr == pm_timer_pkg::period_off;
   assign wr_status = acc_reg.wr &&
                      acc_reg.addr == pm_timer_pkg::int_status_off;
   assign wr_mask   = acc_reg.wr && acc_reg.addr == pm_timer_pkg::int_mask_off;

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = rdata_reg;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         acc_reg <= '0;
      end else begin
         acc_reg <= acc_next;
      end
   end

   // ----------------------------------------------------------------
   // read data, registered in the address phase
   // ----------------------------------------------------------------
   assign rd_take   = take && !hwrite;
   assign rd_ctrl   = {25'h0, ctrl_reg};
   assign rd_count  = {24'h0, count_value_reg};
   assign rd_period = {24'h0, period_value_reg};
   assign rd_status = {31'h0, status_reg};
   assign rd_mask   = {31'h0, mask_reg};

   always_comb begin
      rdata_next = 32'h0;
      if (rd_take) begin
         unique case (haddr[7:0])
            pm_timer_pkg::ctrl_off:       rdata_next = rd_ctrl;
            pm_timer_pkg::count_off:      rdata_next = rd_count;
            pm_timer_pkg::period_off:     rdata_next = rd_period;
            pm_timer_pkg::int_status_off: rdata_next = rd_status;
            pm_timer_pkg::int_mask_off:   rdata_next = rd_mask;
            default:                      rdata_next = 32'h0;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rdata_reg <= 32'h0;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   // ----------------------------------------------------------------
   // control, period and mask registers
   // ----------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_reg         <= pm_timer_pkg::ctrl_rst;
         period_value_reg <= pm_timer_pkg::period_rst;
         mask_reg         <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            ctrl_reg <= hwdata[pm_timer_pkg::ctrl_width-1:0];
         end
         if (wr_period) begin
            period_value_reg <= hwdata[7:0];
         end
         if (wr_mask) begin
            mask_reg <= hwdata[pm_timer_pkg::irq_match_bit];
         end
      end
   end

   // ----------------------------------------------------------------
   // prescaler
   // ----------------------------------------------------------------
   assign presc_clear = wr_ctrl || wr_count;

   prescaler u_prescaler (
      .hclk            (hclk),
      .hresetn         (hresetn),
      .clear           (presc_clear),
      .run             (ctrl_reg.timer_on),
      .prescale_select (ctrl_reg.prescale_select),
      .tick            (tick)
   );

   // ----------------------------------------------------------------
   // count and match
   // ----------------------------------------------------------------
   assign match      = count_value_reg == period_value_reg;
   assign match_tick = tick && match;

   // control writes never touch the count
   always_comb begin
      count_value_next = count_value_reg;
      if (wr_count) begin
         count_value_next = hwdata[7:0];
      end else if (match_tick) begin
         count_value_next = 8'h00;
      end else if (tick) begin
         count_value_next = count_value_reg + 8'h01;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         count_value_reg <= pm_timer_pkg::count_rst;
      end else begin
         count_value_reg <= count_value_next;
      end
   end

   // ----------------------------------------------------------------
   // postscaler and match outputs
   // ----------------------------------------------------------------
   assign post_done = match_tick &&
                      post_cnt_reg == ctrl_reg.postscale_select;
   assign post_cnt_next = presc_clear ? 4'h0 :
                          (post_done ? 4'h0 :
                          (match_tick ? post_cnt_reg + 4'h1 : post_cnt_reg));

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         post_cnt_reg    <= 4'h0;
         match_pulse_reg <= 1'b0;
      end else begin
         post_cnt_reg    <= post_cnt_next;
         match_pulse_reg <= match_tick;
      end
   end

   assign gate_match  = match_pulse_reg;
   assign shift_clock = match_pulse_reg;

   // ----------------------------------------------------------------
   // interrupt status, write one to clear, set wins
   // ----------------------------------------------------------------
   assign status_next = post_done ? 1'b1 :
      ((wr_status && hwdata[pm_timer_pkg::irq_match_bit]) ? 1'b0 : status_reg);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         status_reg <= 1'b0;
      end else begin
         status_reg <= status_next;
      end
   end

   assign irq = status_reg && mask_reg;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   property p_stopped_holds;
      @(posedge hclk) disable iff (!hresetn)
         (!ctrl_reg.timer_on && !wr_count) |=> $stable(count_value_reg);
   endproperty
   a_stopped_holds: assert property (p_stopped_holds)
      else $error("count moved while timer off");

   property p_ctrl_keeps_count;
      @(posedge hclk) disable iff (!hresetn)
         wr_ctrl |=> count_value_reg == $past(count_value_reg);
   endproperty
   a_ctrl_keeps_count: assert property (p_ctrl_keeps_count)
      else $error("control write changed count");

   property p_clear_post;
      @(posedge hclk) disable iff (!hresetn)
         presc_clear |=> post_cnt_reg == 4'h0;
   endproperty
   a_clear_post: assert property (p_clear_post)
      else $error("postscaler not cleared");

   property p_match_wraps;
      @(posedge hclk) disable iff (!hresetn)
         (match_tick && !wr_count) |=> count_value_reg == 8'h00;
   endproperty
   a_match_wraps: assert property (p_match_wraps)
      else $error("count did not wrap after match");

   property p_tick_increments;
      @(posedge hclk) disable iff (!hresetn)
         (tick && !match && !wr_count) |=>
            count_value_reg == $past(count_value_reg) + 8'h01;
   endproperty
   a_tick_increments: assert property (p_tick_increments)
      else $error("count did not advance on tick");

   property p_irq_after_post;
      @(posedge hclk) disable iff (!hresetn)
         post_done |=> status_reg ##0 (irq == mask_reg);
   endproperty
   a_irq_after_post: assert property (p_irq_after_post)
      else $error("status not set after postscale");

   property p_postscale_one;
      @(posedge hclk) disable iff (!hresetn)
         (match_tick && ctrl_reg.postscale_select == 4'h0) |-> post_done;
   endproperty
   a_postscale_one: assert property (p_postscale_one)
      else $error("1:1 postscale missed a match");

   property p_gate_follows;
      @(posedge hclk) disable iff (!hresetn)
         match_tick |=> gate_match && shift_clock;
   endproperty
   a_gate_follows: assert property (p_gate_follows)
      else $error("match output missing");

   property p_period_rw;
      @(posedge hclk) disable iff (!hresetn)
         wr_period |=> period_value_reg == $past(hwdata[7:0]);
   endproperty
   a_period_rw: assert property (p_period_rw)
      else $error("period write lost");

   property p_ctrl_high_zero;
      @(posedge hclk) disable iff (!hresetn)
         (take && !hwrite && haddr[7:0] == pm_timer_pkg::ctrl_off) |=>
            hrdata[31:7] == 25'h0;
   endproperty
   a_ctrl_high_zero: assert property (p_ctrl_high_zero)
      else $error("control upper bits not zero");

   property p_status_sticky;
      @(posedge hclk) disable iff (!hresetn)
         (status_reg && !(wr_status && hwdata[pm_timer_pkg::irq_match_bit]))
            |=> status_reg;
   endproperty
   a_status_sticky: assert property (p_status_sticky)
      else $error("status bit lost without a clear");

   property p_status_clear;
      @(posedge hclk) disable iff (!hresetn)
         (wr_status && hwdata[pm_timer_pkg::irq_match_bit] && !post_done)
            |=> !status_reg;
   endproperty
   a_status_clear: assert property (p_status_clear)
      else $error("status bit not cleared by write");

   property p_count_write;
      @(posedge hclk) disable iff (!hresetn)
         wr_count |=> count_value_reg == $past(hwdata[7:0]);
   endproperty
   a_count_write: assert property (p_count_write)
      else $error("count write lost");

   property p_ctrl_write;
      @(posedge hclk) disable iff (!hresetn)
         wr_ctrl |=>
            ctrl_reg == $past(hwdata[pm_timer_pkg::ctrl_width-1:0]);
   endproperty
   a_ctrl_write: assert property (p_ctrl_write)
      else $error("control write lost");

   property p_post_hold;
      @(posedge hclk) disable iff (!hresetn)
         (!match_tick && !presc_clear) |=>
            post_cnt_reg == $past(post_cnt_reg);
   endproperty
   a_post_hold: assert property (p_post_hold)
      else $error("postscaler moved without a match");

   property p_post_advance;
      @(posedge hclk) disable iff (!hresetn)
         (match_tick && !post_done && !presc_clear) |=>
            post_cnt_reg == $past(post_cnt_reg) + 4'h1;
   endproperty
   a_post_advance: assert property (p_post_advance)
      else $error("postscaler did not advance on match");

   property p_off_no_tick;
      @(posedge hclk) disable iff (!hresetn)
         !ctrl_reg.timer_on |-> !tick;
   endproperty
   a_off_no_tick: assert property (p_off_no_tick)
      else $error("prescaler ticked with timer off");

   property p_read_idle;
      @(posedge hclk) disable iff (!hresetn)
         !rd_take |=> hrdata == 32'h0;
   endproperty
   a_read_idle: assert property (p_read_idle)
      else $error("read data left on bus outside data phase");
endmodule

// ==== dv/period_match_timer_bench.sv ====
`timescale 1ns/1ps
module period_match_timer_bench;
   localparam logic [7:0] a_ctl = pm_timer_pkg::ctrl_off;
   localparam logic [7:0] a_cnt = pm_timer_pkg::count_off;
   localparam logic [7:0] a_per = pm_timer_pkg::period_off;
   localparam logic [7:0] a_sts = pm_timer_pkg::int_status_off;
   localparam logic [7:0] a_msk = pm_timer_pkg::int_mask_off;
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic        irq;
   logic        gate_match;
   logic        shift_clock;
   int          fail_count = 0;
   int          check_count = 0;
   int          seed = 2;

`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin \
   fail_count++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end

   period_match_timer dut (
      .hclk       (hclk),
      .hresetn    (hresetn),
      .hsel       (hsel),
      .haddr      (haddr),
      .htrans     (htrans),
      .hwrite     (hwrite),
      .hsize      (3'h2),
      .hwdata     (hwdata),
      .hready     (hreadyout),
      .hrdata     (hrdata),
      .hreadyout  (hreadyout),
      .hresp      (hresp),
      .irq        (irq),
      .gate_match (gate_match),
      .shift_clock(shift_clock)
   );

   always #25 hclk = ~hclk;

   // ----------------------------------------
   // bus and helper tasks
   // ----------------------------------------
   task automatic final_report();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic hang(input int n);
      if (n > 5000) begin
         fail_count++;
         $display("[FAIL] %0t wait limit reached", $time);
         final_report();
      end
   endtask

   task automatic wait_ready();
      int i;
      i = 0;
      @(posedge hclk);
      while (hreadyout !== 1'b1) begin
         i++;
         hang(i * 100);
         @(posedge hclk);
      end
   endtask

   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      wait_ready();
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= w ? d : 32'h0;
      wait_ready();
      r = hrdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      xfer(1'b1, a, d, r);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] r;
      xfer(1'b0, a, 32'h0, r);
      `CHK(r, e)
   endtask

   // cycles until the next match pulse
   task automatic wait_gate(output int n);
      n = 0;
      do begin
         @(posedge hclk);
         n++;
         hang(n);
      end while (gate_match !== 1'b1);
      `CHK(shift_clock, 1'b1)
   endtask

   function automatic int div(input int s);
      return (s == 0) ? 1 : ((s == 1) ? 4 : 16);
   endfunction

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      int n, m, p, k;
      int lat[4];
      logic [31:0] v;
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rd_chk(a_ctl, {25'h0, pm_timer_pkg::ctrl_rst});
      rd_chk(a_cnt, {24'h0, pm_timer_pkg::count_rst});
      rd_chk(a_per, {24'h0, pm_timer_pkg::period_rst});
      rd_chk(a_sts, 32'h0);
      rd_chk(8'h14, 32'h0);
      `CHK(hresp, 1'b0)
      `CHK(irq, 1'b0)
      $display("test reset done");
      for (k = 0; k < 6; k++) begin
         v = $random(seed);
         wr(a_cnt, v);
         rd_chk(a_cnt, v & 32'hff);
         wr(a_per, v >> 8);
         rd_chk(a_per, (v >> 8) & 32'hff);
         wr(a_ctl, (v >> 4) & ~32'h4);
         rd_chk(a_ctl, (v >> 4) & 32'h7b);
         rd_chk(a_cnt, v & 32'hff);
      end
      repeat (40) @(posedge hclk);
      rd_chk(a_cnt, v & 32'hff);
      $display("test registers done");
      for (k = 0; k < 4; k++) begin
         p = 1 + ($random(seed) & 3);
         wr(a_ctl, 32'h0);
         wr(a_cnt, 32'h0);
         wr(a_per, p);
         wr(a_ctl, 32'h4 | k);
         wait_gate(n);
         wait_gate(n);
         `CHK(n, (p + 1) * div(k))
         @(posedge hclk);
         `CHK(gate_match, 1'b0)
      end
      $display("test prescale done");
      for (k = 0; k < 4; k++) begin
         p = (k == 3) ? 15 : ((k == 0) ? 0 : ($random(seed) & 15));
         wr(a_ctl, 32'h0);
         wr(a_cnt, 32'h0);
         wr(a_per, 32'h2);
         wr(a_sts, 32'h1);
         wr(a_msk, 32'h1);
         `CHK(irq, 1'b0)
         wr(a_ctl, (p << 3) | 4);
         m = 0;
         n = 0;
         while (irq !== 1'b1) begin
            @(posedge hclk);
            n++;
            hang(n);
            if (gate_match === 1'b1) m++;
         end
         `CHK(m, p + 1)
      end
      wr(a_ctl, 32'h0);
      wr(a_msk, 32'h0);
      @(posedge hclk);
      `CHK(irq, 1'b0)
      rd_chk(a_sts, 32'h1);
      wr(a_msk, 32'h1);
      @(posedge hclk);
      `CHK(irq, 1'b1)
      wr(a_sts, 32'h1);
      @(posedge hclk);
      `CHK(irq, 1'b0)
      $display("test postscale done");
      wr(a_per, 32'hff);
      wr(a_cnt, 32'h0);
      wr(a_ctl, 32'h6);
      for (k = 0; k < 4; k++) begin
         if (k < 2) begin
            repeat (k * 7 + 3) @(posedge hclk);
            wr(a_cnt, 32'hff);
         end else begin
            wr(a_cnt, 32'hfe);
            repeat (k * 7 - 12) @(posedge hclk);
            wr(a_ctl, 32'h6);
         end
         wait_gate(lat[k]);
      end
      `CHK(lat[0], lat[1])
      `CHK(lat[2], lat[3])
      `CHK(lat[0], div(2) + 1)
      `CHK(lat[2], 2 * div(2) + 1)
      $display("test clear done");
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      `CHK(gate_match, 1'b0)
      rd_chk(a_ctl, {25'h0, pm_timer_pkg::ctrl_rst});
      rd_chk(a_cnt, {24'h0, pm_timer_pkg::count_rst});
      wr(a_per, 32'h1);
      wr(a_ctl, 32'h4);
      wait_gate(n);
      `CHK(n, 2 * div(0) + 1)
      $display("test mid reset done");
      final_report();
   end
endmodule
